//--- hw/dspace_pkg.sv
package dspace_pkg;

  // data space map
  localparam logic [15:0] REGFILE_BASE = 16'h0000;
  localparam logic [15:0] STD_IO_BASE = 16'h0020;
  localparam logic [15:0] EXT_IO_BASE = 16'h0060;
  localparam logic [15:0] SRAM_BASE = 16'h0100;
  localparam logic [15:0] SRAM_TOP = 16'h08ff;
  localparam logic [15:0] DATA_TOP = 16'hffff;
  localparam logic [5:0] IO_SHORT_OFFSET = 6'h20;
  localparam logic [5:0] IO_BIT_LIMIT = 6'h1f;
  localparam int PC_W = 14;
  localparam int PROG_DEPTH = 16384;
  localparam int EE_AW = 10;
  localparam int EE_DEPTH = 1024;
  localparam int SRAM_AW = 11;
  localparam int SRAM_DEPTH = 2048;

  // stall lengths in cpu clock cycles
  localparam logic [2:0] EE_RD_STALL = 3'h4;
  localparam logic [2:0] EE_WR_STALL = 3'h2;
  localparam logic [1:0] SRAM_CYCLES = 2'h2;
  // eeprom program time, 3.4 ms at 10 MHz
  localparam int EE_PROG_US = 3400;
  localparam int CLK_MHZ = 10;
  localparam int EE_PROG_CYC = EE_PROG_US * CLK_MHZ;
  localparam int DISP_MAX = 63;

  // scratch and 16-bit access registers, short i/o addresses; temp byte by data space address
  localparam logic [5:0] SCRATCH0_IO = 6'h1e;
  localparam logic [5:0] SCRATCH1_IO = 6'h2a;
  localparam logic [5:0] SCRATCH2_IO = 6'h2b;
  localparam logic [5:0] EE_DATA_IO = 6'h20;
  localparam logic [5:0] EE_ADDR_LO_IO = 6'h21;
  localparam logic [5:0] EE_ADDR_HI_IO = 6'h22;
  localparam logic [5:0] EE_CTRL_IO = 6'h1f;
  localparam logic [15:0] TEMP_DS = 16'h0080;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [2:0] {
    OP_LOAD, OP_STORE, OP_IN, OP_OUT, OP_SETBIT, OP_CLRBIT, OP_SKIPSET, OP_SKIPCLR
  } op_t;

  typedef enum logic [2:0] {
    SEL_REG, SEL_STDIO, SEL_EXTIO, SEL_SRAM, SEL_NONE
  } sel_t;

  // one cpu data request
  typedef struct packed {
    logic valid;
    op_t op;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [2:0] bitn;
  } dreq_t;

  // pointer address mode request
  typedef struct packed {
    logic valid;
    logic [1:0] ptr;
    logic [1:0] mode;
    logic [5:0] disp;
  } pmode_t;

  localparam logic [1:0] PM_PLAIN = 2'h0;
  localparam logic [1:0] PM_DISP = 2'h1;
  localparam logic [1:0] PM_PREDEC = 2'h2;
  localparam logic [1:0] PM_POSTINC = 2'h3;

endpackage : dspace_pkg

//--- hw/space_sel.sv
`timescale 1ns/1ns
`default_nettype none
// combinational region decode of one data space address
module space_sel
  import dspace_pkg::*;
(
  input wire logic [15:0] addr_i,
  output sel_t sel_o
);
  // region boundaries ascend, so the first match wins
  always_comb begin
    if (addr_i < STD_IO_BASE) sel_o = SEL_REG;
    else if (addr_i < EXT_IO_BASE) sel_o = SEL_STDIO;
    else if (addr_i < SRAM_BASE) sel_o = SEL_EXTIO;
    else if (addr_i <= SRAM_TOP) sel_o = SEL_SRAM;
    else sel_o = SEL_NONE;
  end
endmodule : space_sel
`default_nettype wire

//--- hw/data_space_decoder.sv
// Contract
// - program store 16K words, 14-bit counter
// - decode registers, std i/o, ext i/o, sram
// - short i/o address plus 0x20 offset
// - extended i/o only via load/store
// - sram access takes two cycles
// - bit ops only on low 32 i/o
// - bit ops modify only the addressed bit
// - eeprom read stalls cpu four cycles
// - eeprom write stalls cpu two cycles
// - eeprom write self-timed, busy flag visible
// - reset does not abort eeprom write
// - one kilobyte byte-wide eeprom space
// - high to temp, low loads both
// - low read latches high into temp
// - temp byte directly readable and writable
// - three scratch registers, only the one at 0x1e bit-addressable
// - displacement reaches 63 beyond y or z
// - pre-dec/post-inc update pointer pair
`timescale 1ns/1ns
`default_nettype none
module data_space_decoder
  import dspace_pkg::*;
#(
  parameter int EE_PROG_CYCLES = EE_PROG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire dreq_t req_i,
  input wire pmode_t pm_i,
  input wire logic [PC_W-1:0] pc_i,
  input wire logic [15:0] prog_wdata_i,
  input wire logic prog_we_i,
  output logic [15:0] prog_word_o,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic skip_o,
  output logic stall_o,
  output logic illegal_o,
  output logic ee_busy_o
);

  typedef enum {ST_IDLE, ST_SRAM, ST_STALL} st_t;

  localparam logic [15:0] EE_PROG_LEN = 16'(EE_PROG_CYCLES);

  // storage
  logic [15:0] prog_mem [PROG_DEPTH];
  logic [7:0] sram_mem [SRAM_DEPTH];
  logic [7:0] ee_mem [EE_DEPTH];
  logic [7:0] regs_r [32];
  logic [7:0] regs_nxt [32];
  logic [7:0] scratch_r [3];
  logic [7:0] scratch_nxt [3];
  logic [7:0] temp_r, temp_nxt;
  logic [7:0] ee_data_r, ee_data_nxt;
  logic [EE_AW-1:0] ee_addr_r, ee_addr_nxt;
  logic [15:0] ee_cnt_r, ee_cnt_nxt;
  logic [EE_AW-1:0] ee_waddr_r, ee_waddr_nxt;
  logic [7:0] ee_wbyte_r, ee_wbyte_nxt;
  logic ee_busy_r, ee_busy_nxt;
  st_t st_r, st_nxt;
  logic [2:0] stall_cnt_r, stall_cnt_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic skip_r, skip_nxt;
  logic illegal_r, illegal_nxt;
  logic [15:0] prog_word_r;
  logic stall_r, stall_nxt;
  logic [10:0] sram_addr_r, sram_addr_nxt;
  logic [15:0] daddr;
  logic [10:0] sram_idx;
  sel_t sel;

  // short i/o forms are rebased into data space
  always_comb begin
    logic [15:0] base;
    base = {regs_r[5'd27 + 5'({pm_i.ptr, 1'b0})], regs_r[5'd26 + 5'({pm_i.ptr, 1'b0})]};
    if (pm_i.valid) begin
      unique case (pm_i.mode)
        PM_DISP: daddr = base + {10'h000, pm_i.disp};
        PM_PREDEC: daddr = base - 16'h0001;
        default: daddr = base;
      endcase
    end else if (req_i.op inside {OP_LOAD, OP_STORE}) begin
      daddr = req_i.addr;
    end else begin
      daddr = {10'h000, req_i.addr[5:0]} + {10'h000, IO_SHORT_OFFSET};
    end
  end

  space_sel u_sel (
    .addr_i(daddr),
    .sel_o(sel)
  );

  assign sram_idx = 11'(daddr - SRAM_BASE);

  // read mux shared by loads, in and bit tests
  function automatic logic [7:0] rd_byte(input logic [15:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a < STD_IO_BASE) v = regs_r[a[4:0]];
    else if (a == TEMP_DS) v = temp_r;
    else if (a == {10'h000, SCRATCH0_IO} + 16'h0020) v = scratch_r[0];
    else if (a == {10'h000, SCRATCH1_IO} + 16'h0020) v = scratch_r[1];
    else if (a == {10'h000, SCRATCH2_IO} + 16'h0020) v = scratch_r[2];
    else if (a == {10'h000, EE_DATA_IO} + 16'h0020) v = ee_data_r;
    else if (a == {10'h000, EE_ADDR_LO_IO} + 16'h0020) v = ee_addr_r[7:0];
    else if (a == {10'h000, EE_ADDR_HI_IO} + 16'h0020) v = temp_r;
    else if (a == {10'h000, EE_CTRL_IO} + 16'h0020) v = {6'h00, ee_busy_r, 1'b0};
    rd_byte = v;
  endfunction

  // main access sequencer
  always_comb begin
    logic [7:0] cur;
    logic [7:0] wv;
    logic is_bit, acc, wr;
    logic [15:0] ptr;
    ptr = 16'h0000;
    cur = rd_byte(daddr);
    wv = req_i.wdata;
    is_bit = req_i.op inside {OP_SETBIT, OP_CLRBIT, OP_SKIPSET, OP_SKIPCLR};
    regs_nxt = regs_r;
    scratch_nxt = scratch_r;
    temp_nxt = temp_r;
    ee_data_nxt = ee_data_r;
    ee_addr_nxt = ee_addr_r;
    ee_cnt_nxt = ee_cnt_r;
    ee_waddr_nxt = ee_waddr_r;
    ee_wbyte_nxt = ee_wbyte_r;
    ee_busy_nxt = ee_busy_r;
    st_nxt = st_r;
    stall_cnt_nxt = stall_cnt_r;
    sram_addr_nxt = sram_addr_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    skip_nxt = 1'b0;
    illegal_nxt = 1'b0;
    acc = 1'b0;
    wr = 1'b0;
    // self-timed programming counts down while busy
    if (ee_busy_r) begin
      if (ee_cnt_r == 16'h0001) ee_busy_nxt = 1'b0;
      ee_cnt_nxt = ee_cnt_r - 16'h0001;
    end
    unique case (st_r)
      ST_IDLE: begin
        if (req_i.valid) begin
          acc = 1'b1;
          if (is_bit && req_i.addr[5:0] > IO_BIT_LIMIT) begin
            acc = 1'b0;
            illegal_nxt = 1'b1;
          end else if (!(req_i.op inside {OP_LOAD, OP_STORE}) && req_i.addr[15:6] != 10'h000) begin
            acc = 1'b0;
            illegal_nxt = 1'b1;
          end else if (sel == SEL_NONE) begin
            acc = 1'b0;
            illegal_nxt = 1'b1;
          end
        end
        if (acc) begin
          wr = req_i.op inside {OP_STORE, OP_OUT, OP_SETBIT, OP_CLRBIT};
          // single-bit ops touch only the addressed bit
          if (req_i.op == OP_SETBIT) wv = cur | (8'h01 << req_i.bitn);
          if (req_i.op == OP_CLRBIT) wv = cur & ~(8'h01 << req_i.bitn);
          if (req_i.op == OP_SKIPSET) skip_nxt = cur[req_i.bitn];
          if (req_i.op == OP_SKIPCLR) skip_nxt = !cur[req_i.bitn];
          if (!wr) begin
            rdata_nxt = cur;
            rvalid_nxt = !is_bit && sel != SEL_SRAM;
          end
          if (sel == SEL_SRAM) begin
            st_nxt = ST_SRAM;
            // pointer modes move the base, so the index is frozen at the take
            sram_addr_nxt = sram_idx;
          end else if (wr) begin
            if (daddr < STD_IO_BASE) regs_nxt[daddr[4:0]] = wv;
            else if (daddr == TEMP_DS) temp_nxt = wv;
            else if (daddr == {10'h000, SCRATCH0_IO} + 16'h0020) scratch_nxt[0] = wv;
            else if (daddr == {10'h000, SCRATCH1_IO} + 16'h0020) scratch_nxt[1] = wv;
            else if (daddr == {10'h000, SCRATCH2_IO} + 16'h0020) scratch_nxt[2] = wv;
            else if (daddr == {10'h000, EE_DATA_IO} + 16'h0020) ee_data_nxt = wv;
            else if (daddr == {10'h000, EE_ADDR_HI_IO} + 16'h0020) temp_nxt = wv;
            else if (daddr == {10'h000, EE_ADDR_LO_IO} + 16'h0020) begin
              ee_addr_nxt = {temp_r[1:0], wv};
            end else if (daddr == {10'h000, EE_CTRL_IO} + 16'h0020) begin
              if (wv[1] && !ee_busy_r) begin
                ee_busy_nxt = 1'b1;
                ee_cnt_nxt = EE_PROG_LEN;
                ee_waddr_nxt = ee_addr_r;
                ee_wbyte_nxt = ee_data_r;
                st_nxt = ST_STALL;
                stall_cnt_nxt = EE_WR_STALL;
              end else if (wv[0] && !ee_busy_r) begin
                ee_data_nxt = ee_mem[ee_addr_r];
                st_nxt = ST_STALL;
                stall_cnt_nxt = EE_RD_STALL;
              end
            end
          end else if (daddr == {10'h000, EE_ADDR_LO_IO} + 16'h0020) begin
            temp_nxt = {6'h00, ee_addr_r[9:8]};
          end
          // pointer update after the access
          if (pm_i.valid && (pm_i.mode == PM_PREDEC || pm_i.mode == PM_POSTINC)) begin
            ptr = pm_i.mode == PM_PREDEC ? daddr : daddr + 16'h0001;
            regs_nxt[5'd26 + 5'({pm_i.ptr, 1'b0})] = ptr[7:0];
            regs_nxt[5'd27 + 5'({pm_i.ptr, 1'b0})] = ptr[15:8];
          end
        end
      end
      ST_SRAM: begin
        // second cycle of the sram access
        st_nxt = ST_IDLE;
        if (!(req_i.op inside {OP_STORE, OP_OUT})) begin
          rvalid_nxt = 1'b1;
          rdata_nxt = sram_mem[sram_addr_r];
        end
      end
      ST_STALL: begin
        stall_cnt_nxt = stall_cnt_r - 3'h1;
        if (stall_cnt_r == 3'h1) st_nxt = ST_IDLE;
      end
    endcase
    stall_nxt = st_nxt != ST_IDLE;
  end

  // reset leaves a running eeprom write alone
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (rst_i) begin
        st_r <= ST_IDLE;
        stall_r <= 1'b0;
        sram_addr_r <= '0;
        stall_cnt_r <= 3'h0;
        rdata_r <= RESET_BYTE;
        rvalid_r <= 1'b0;
        skip_r <= 1'b0;
        illegal_r <= 1'b0;
        temp_r <= RESET_BYTE;
        ee_data_r <= RESET_BYTE;
        ee_addr_r <= '0;
        for (int i = 0; i < 32; i++) regs_r[i] <= RESET_BYTE;
        for (int i = 0; i < 3; i++) scratch_r[i] <= RESET_BYTE;
      end else begin
        st_r <= st_nxt;
        stall_r <= stall_nxt;
        sram_addr_r <= sram_addr_nxt;
        stall_cnt_r <= stall_cnt_nxt;
        rdata_r <= rdata_nxt;
        rvalid_r <= rvalid_nxt;
        skip_r <= skip_nxt;
        illegal_r <= illegal_nxt;
        temp_r <= temp_nxt;
        ee_data_r <= ee_data_nxt;
        ee_addr_r <= ee_addr_nxt;
        regs_r <= regs_nxt;
        scratch_r <= scratch_nxt;
      end
      // a running write timer is exempt from reset, only cleared by completion
      // an idle or unknown timer is cleared by reset, a running one keeps going
      if (!rst_i || ee_busy_r) ee_busy_r <= ee_busy_nxt;
      else ee_busy_r <= 1'b0;
      ee_cnt_r <= ee_cnt_nxt;
      ee_waddr_r <= ee_waddr_nxt;
      ee_wbyte_r <= ee_wbyte_nxt;
      if (ee_busy_r && ee_cnt_r == 16'h0001) ee_mem[ee_waddr_r] <= ee_wbyte_r;
    end
  end

  // memories, sram completes in the second cycle
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      prog_word_r <= prog_mem[pc_i];
      if (prog_we_i) prog_mem[pc_i] <= prog_wdata_i;
      if (st_r == ST_SRAM && req_i.op inside {OP_STORE, OP_OUT}) begin
        sram_mem[sram_addr_r] <= req_i.wdata;
      end
    end
  end

  // outputs are registered
  assign prog_word_o = prog_word_r;
  assign rdata_o = rdata_r;
  assign rvalid_o = rvalid_r;
  assign skip_o = skip_r;
  assign stall_o = stall_r;
  assign illegal_o = illegal_r;
  assign ee_busy_o = ee_busy_r;

  a_sram_two_cycles: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_r == ST_IDLE && st_nxt == ST_SRAM |=> st_r == ST_SRAM ##1 (!ce_i || st_r == ST_IDLE))
    else $error("sram access did not finish in two cycles");

  a_bit_op_range: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_r == ST_IDLE && req_i.valid && req_i.op == OP_SETBIT && req_i.addr[5] |=> illegal_r)
    else $error("bit op above low i/o range accepted");

  a_ee_busy_hold: assert property (@(posedge clk_i)
    ce_i && ee_busy_r && ee_cnt_r > 16'h0001 |=> !ce_i || ee_busy_r)
    else $error("eeprom write aborted early");

  a_stall_len_rd: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_r == ST_STALL && stall_cnt_r == 3'h4 |=> !ce_i || stall_cnt_r == 3'h3)
    else $error("eeprom read stall miscounted");

  a_ee_wr_stall: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    !ee_busy_r && ee_busy_nxt |=> stall_o [*2] ##1 !stall_o)
    else $error("eeprom write stall not two cycles");

  a_refuse_ext_io: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    st_r == ST_IDLE && req_i.valid && req_i.op inside {OP_IN, OP_OUT}
    && req_i.addr[15:6] != 10'h000 |=> illegal_o && !rvalid_o)
    else $error("short i/o beyond low range accepted");

endmodule : data_space_decoder
`default_nettype wire

//--- dv/cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// cpu core side: one data request at a time, held through any stall
module cpu_model
  import dspace_pkg::*;
(
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  input wire logic skip_i,
  input wire logic illegal_i,
  output dreq_t req_o,
  output pmode_t pm_o
);
  logic [7:0] rd;
  logic got;
  logic skp;
  logic ill;
  logic [3:0] nstall;

  initial begin
    req_o = '0;
    pm_o = '0;
  end

  // called at a falling edge; watches eight cycles so slow answers are caught too
  task automatic access(input op_t op, input logic [15:0] a, input logic [7:0] d,
                        input logic [2:0] b, input pmode_t pm);
    got = 1'b0;
    skp = 1'b0;
    ill = 1'b0;
    nstall = 4'h0;
    rd = 8'h00;
    req_o <= '{1'b1, op, a, d, b};
    pm_o <= pm;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_i);
      if (stall_i) begin
        nstall = nstall + 4'h1;
      end else if (req_o.valid) begin
        // released lines show inverted address, data, bit and pointer fields; op is kept
        req_o <= '{1'b0, op, ~a, ~d, ~b};
        pm_o <= '{1'b0, ~pm.ptr, ~pm.mode, ~pm.disp};
      end
      if (rvalid_i) begin
        got = 1'b1;
        rd = rdata_i;
      end
      skp = skp | skip_i;
      ill = ill | illegal_i;
    end
  endtask : access
endmodule : cpu_model
`default_nettype wire

//--- dv/tb_data_space_decoder.sv
`timescale 1ns/1ns
`default_nettype none
module tb_data_space_decoder
  import dspace_pkg::*;
  ;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  dreq_t req;
  pmode_t pm;
  logic [13:0] pc = 14'h0000;
  logic [15:0] pwd = 16'h0000;
  logic pwe = 1'b0;
  logic [15:0] pword;
  logic [7:0] rdata;
  logic rvalid, skip, stall, illegal, busy;
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;

  always #50 clk_i = ~clk_i;

  // long program time cut to keep the run short
  data_space_decoder #(.EE_PROG_CYCLES(40)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .req_i(req), .pm_i(pm), .pc_i(pc), .prog_wdata_i(pwd), .prog_we_i(pwe),
    .prog_word_o(pword), .rdata_o(rdata), .rvalid_o(rvalid), .skip_o(skip),
    .stall_o(stall), .illegal_o(illegal), .ee_busy_o(busy));

  cpu_model cpu (.clk_i(clk_i), .stall_i(stall), .rdata_i(rdata), .rvalid_i(rvalid),
    .skip_i(skip), .illegal_i(illegal), .req_o(req), .pm_o(pm));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic ac(input op_t op, input logic [15:0] a, input logic [7:0] d,
                    input logic [2:0] b = 3'h0);
    cpu.access(op, a, d, b, '0);
  endtask : ac

  // bounded wait for the self-timed write to finish
  task automatic wait_busy();
    for (int i = 0; i < 80 && busy === 1'b1; i++) @(negedge clk_i);
    check(busy, 1'b0);
  endtask : wait_busy

  task automatic t_prog();
    pwe = 1'b1;
    pc = 14'h3fff;
    pwd = 16'hbeef;
    @(negedge clk_i);
    pc = 14'h0000;
    pwd = 16'h1234;
    @(negedge clk_i);
    pwe = 1'b0;
    pc = 14'h3fff;
    repeat (2) @(negedge clk_i);
    check(pword, 16'hbeef);
    pc = 14'h0000;
    repeat (2) @(negedge clk_i);
    check(pword, 16'h1234);
    // with the enable low the fetched word must not follow the counter
    ce_i = 1'b0;
    pc = 14'h3fff;
    repeat (2) @(negedge clk_i);
    check(pword, 16'h1234);
    ce_i = 1'b1;
  endtask : t_prog

  task automatic t_io();
    ac(OP_OUT, 16'h002a, 8'h3c);
    ac(OP_LOAD, 16'h004a, 8'h00);
    check({cpu.got, cpu.rd}, 9'h13c);
    ac(OP_STORE, 16'h004b, 8'hc3);
    ac(OP_IN, 16'h002b, 8'h00);
    check({cpu.got, cpu.rd}, 9'h1c3);
    ac(OP_OUT, 16'h0040, 8'h55);
    check(cpu.ill, 1'b1);
    ac(OP_STORE, 16'h0080, 8'h5a);
    ac(OP_LOAD, 16'h0080, 8'h00);
    check({cpu.got, cpu.rd}, 9'h15a);
  endtask : t_io

  task automatic t_sram();
    ac(OP_STORE, 16'h0100, 8'h11);
    check(cpu.nstall, 4'h1);
    ac(OP_STORE, 16'h08ff, 8'h22);
    ac(OP_LOAD, 16'h0100, 8'h00);
    check({cpu.nstall, cpu.got, cpu.rd}, 13'h0311);
    ac(OP_LOAD, 16'h08ff, 8'h00);
    check({cpu.got, cpu.rd}, 9'h122);
    ac(OP_STORE, 16'h001f, 8'h44);
    ac(OP_LOAD, 16'h001f, 8'h00);
    check({cpu.nstall, cpu.got, cpu.rd}, 13'h0144);
    ac(OP_LOAD, 16'h0900, 8'h00);
    check(cpu.ill, 1'b1);
  endtask : t_sram

  // scratch register at 0x1e is bit addressable, 0x2a is not
  task automatic t_bits();
    ac(OP_OUT, 16'h001e, 8'ha5);
    ac(OP_SETBIT, 16'h001e, 8'h00, 3'h1);
    ac(OP_CLRBIT, 16'h001e, 8'h00, 3'h0);
    ac(OP_IN, 16'h001e, 8'h00);
    check({cpu.got, cpu.rd}, 9'h1a6);
    ac(OP_SKIPSET, 16'h001e, 8'h00, 3'h1);
    check(cpu.skp, 1'b1);
    ac(OP_SKIPCLR, 16'h001e, 8'h00, 3'h1);
    check(cpu.skp, 1'b0);
    ac(OP_SKIPCLR, 16'h001e, 8'h00, 3'h0);
    check(cpu.skp, 1'b1);
    ac(OP_SETBIT, 16'h002a, 8'h00, 3'h0);
    check(cpu.ill, 1'b1);
  endtask : t_bits

  task automatic t_word();
    ac(OP_OUT, 16'h0022, 8'h02);
    ac(OP_LOAD, 16'h0080, 8'h00);
    check(cpu.rd, 8'h02);
    ac(OP_OUT, 16'h0021, 8'h34);
    ac(OP_STORE, 16'h0080, 8'h00);
    ac(OP_IN, 16'h0021, 8'h00);
    check(cpu.rd, 8'h34);
    ac(OP_LOAD, 16'h0080, 8'h00);
    check(cpu.rd, 8'h02);
    ac(OP_IN, 16'h0022, 8'h00);
    check(cpu.rd, 8'h02);
  endtask : t_word

  task automatic t_ptr();
    ac(OP_STORE, 16'h001c, 8'h00);
    ac(OP_STORE, 16'h001d, 8'h01);
    ac(OP_STORE, 16'h013f, 8'h77);
    cpu.access(OP_LOAD, 16'h0000, 8'h00, 3'h0, '{1'b1, 2'h1, PM_DISP, 6'h3f});
    check(cpu.rd, 8'h77);
    cpu.access(OP_LOAD, 16'h0000, 8'h00, 3'h0, '{1'b1, 2'h1, PM_POSTINC, 6'h00});
    check(cpu.rd, 8'h11);
    ac(OP_LOAD, 16'h001c, 8'h00);
    check(cpu.rd, 8'h01);
    ac(OP_STORE, 16'h001a, 8'h01);
    ac(OP_STORE, 16'h001b, 8'h01);
    cpu.access(OP_LOAD, 16'h0000, 8'h00, 3'h0, '{1'b1, 2'h0, PM_PREDEC, 6'h00});
    check(cpu.rd, 8'h11);
    ac(OP_LOAD, 16'h001a, 8'h00);
    check({cpu.got, cpu.rd}, 9'h100);
  endtask : t_ptr

  task automatic t_ee();
    ac(OP_OUT, 16'h0022, 8'h02);
    ac(OP_OUT, 16'h0021, 8'h34);
    ac(OP_OUT, 16'h0020, 8'h5c);
    ac(OP_OUT, 16'h001f, 8'h02);
    check(cpu.nstall, 4'h2);
    check(busy, 1'b1);
    // software sees the running write through the control byte
    ac(OP_IN, 16'h001f, 8'h00);
    check({cpu.got, cpu.rd}, 9'h102);
    wait_busy();
    ac(OP_STORE, 16'h0040, 8'h00);
    ac(OP_OUT, 16'h001f, 8'h01);
    check(cpu.nstall, 4'h4);
    ac(OP_IN, 16'h0020, 8'h00);
    check(cpu.rd, 8'h5c);
    ac(OP_OUT, 16'h0020, 8'ha1);
    ac(OP_OUT, 16'h001f, 8'h02);
    rst_i = 1'b1;
    @(negedge clk_i);
    rst_i = 1'b0;
    check(busy, 1'b1);
    wait_busy();
    // address register may reset, so it is set again before reading back
    ac(OP_OUT, 16'h0022, 8'h02);
    ac(OP_OUT, 16'h0021, 8'h34);
    ac(OP_OUT, 16'h001f, 8'h01);
    ac(OP_IN, 16'h0020, 8'h00);
    check(cpu.rd, 8'ha1);
  endtask : t_ee

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // hang guard, well above the roughly 500 cycles the scenarios need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    t_prog();
    t_io();
    t_sram();
    t_bits();
    t_word();
    t_ptr();
    t_ee();
    give_verdict();
  end
endmodule : tb_data_space_decoder
`default_nettype wire
